/* logic/ebdp_bus_ctrl.sv */
`timescale 1ns/1ns
module ebdp_bus_ctrl
	import ebdp_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// core requests
	input  wire logic        reqValid,
	input  wire ebdp_req_t   req,
	output logic             reqReady,
	output logic             doneValid,
	output logic [7:0]       doneData,
	output logic             doneExternal,
	// special registers
	input  wire logic        sfrWe,
	input  wire logic [7:0]  sfrAddr,
	input  wire logic [7:0]  sfrWdata,
	input  wire logic        ptrInc,
	output logic [7:0]       sfrRdata,
	output logic [15:0]      activePointer,
	// system straps and port 2 latch contents
	input  wire logic        extAccessInN,
	input  wire logic [7:0]  port2Latch,
	output logic             port0LatchLoadOnes,
	output logic             port2Dedicated,
	// bus pins
	input  wire logic [7:0]  port0In,
	output ebdp_pins_t       pins
);

	typedef struct packed {
		ebdp_state_t state;
		logic [3:0]  cnt;
		ebdp_op_t    op;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
		logic [2:0]  select;
		logic        extExec;
		logic [7:0]  lastHigh;
		logic        ready;
		logic        done;
		logic        doneExt;
		logic [7:0]  sfrRd;
		logic        loadOnes;
		ebdp_pins_t  pins;
	} ebdp_ctrl_t;

	ebdp_ctrl_t  s_q;
	ebdp_ctrl_t  s_d;

	logic [15:0] bankRd;
	logic        bankWe;
	logic [1:0]  bankMask;
	logic [15:0] bankWdata;
	logic        goExternal;
	logic [15:0] busAddr;

	ebdp_ptr_bank #(
		.DEPTH (PTR_COUNT),
		.WIDTH (PTR_WIDTH),
		.IDXW  (SEL_WIDTH)
	) u_bank (
		.clk    (clk),
		.rst_n  (rst_n),
		.wrEn   (bankWe),
		.wrIdx  (s_q.select),
		.wrMask (bankMask),
		.wrData (bankWdata),
		.rdIdx  (s_d.select),
		.rdData (bankRd)
	);

	assign goExternal = (req.op != OP_FETCH) || !extAccessInN
		|| (req.addr > INTERNAL_CODE_TOP);

	// pointer mode takes the whole pointer, register mode pages by port 2
	always_comb begin
		if (req.op != OP_FETCH && req.viaPointer) begin
			busAddr = bankRd;
		end else if (req.op != OP_FETCH) begin
			busAddr = {port2Latch, req.addr[7:0]};
		end else begin
			busAddr = req.addr;
		end
	end

	// byte writes and increment reach the selected pointer only
	always_comb begin
		bankWe    = 1'b0;
		bankMask  = 2'b00;
		bankWdata = bankRd;
		if (sfrWe && sfrAddr == SFR_PTR_LOW) begin
			bankWe    = 1'b1;
			bankMask  = 2'b01;
			bankWdata = {8'h00, sfrWdata};
		end else if (sfrWe && sfrAddr == SFR_PTR_HIGH) begin
			bankWe    = 1'b1;
			bankMask  = 2'b10;
			bankWdata = {sfrWdata, 8'h00};
		end else if (ptrInc) begin
			bankWe    = 1'b1;
			bankMask  = 2'b11;
			bankWdata = bankRd + 16'h0001;
		end
	end

	always_comb begin
		s_d          = s_q;
		s_d.done     = 1'b0;
		s_d.loadOnes = 1'b0;

		// select field in bits 2:0, used from next cycle on
		if (sfrWe && sfrAddr == SFR_PTR_SELECT) begin
			s_d.select = sfrWdata[2:0];
		end

		case (s_q.state)
			ST_IDLE: begin
				if (reqValid && s_q.ready) begin
					s_d.op    = req.op;
					s_d.addr  = busAddr;
					s_d.wdata = req.wdata;
					if (!goExternal) begin
						// internal fetch: answered at once, bus untouched
						s_d.done    = 1'b1;
						s_d.doneExt = 1'b0;
						s_d.extExec = 1'b0;
					end else begin
						s_d.state    = ST_ADDR;
						s_d.cnt      = ADDR_CYCLES - 4'h1;
						s_d.ready    = 1'b0;
						// port 0 latch lost to the bus
						s_d.loadOnes = 1'b1;
						if (req.op == OP_FETCH) begin
							s_d.extExec = 1'b1;
						end
					end
				end
			end
			ST_ADDR: begin
				if (s_q.cnt == 4'h0) begin
					s_d.state = ST_ALEOFF;
				end else begin
					s_d.cnt = s_q.cnt - 4'h1;
				end
			end
			ST_ALEOFF: begin
				if (s_q.op == OP_WRITE) begin
					s_d.state = ST_SETUP;
				end else begin
					s_d.state = ST_STROBE;
					s_d.cnt   = (s_q.op == OP_FETCH) ? CODE_STROBE_CYCLES - 4'h1
						: DATA_STROBE_CYCLES - 4'h1;
				end
			end
			ST_SETUP: begin
				s_d.state = ST_STROBE;
				s_d.cnt   = DATA_STROBE_CYCLES - 4'h1;
			end
			ST_STROBE: begin
				if (s_q.cnt == 4'h0) begin
					// strobe output is still low in this cycle
					if (s_q.op != OP_WRITE) begin
						s_d.rdata = port0In;
					end
					s_d.state = ST_RELEASE;
				end else begin
					s_d.cnt = s_q.cnt - 4'h1;
				end
			end
			ST_RELEASE: begin
				s_d.state   = ST_IDLE;
				s_d.ready   = 1'b1;
				s_d.done    = 1'b1;
				s_d.doneExt = 1'b1;
			end
			default: begin
				s_d.state = ST_IDLE;
				s_d.ready = 1'b1;
			end
		endcase

		if (s_d.state == ST_ADDR && s_q.state == ST_IDLE) begin
			s_d.lastHigh = busAddr[15:8];
		end

		// pin values follow the state entered at this edge
		s_d.pins = PINS_RESET;
		// while code runs externally port 2 keeps the address
		if (s_d.extExec) begin
			s_d.pins.port2Out = s_d.lastHigh;
		end else begin
			s_d.pins.port2Out = port2Latch;
		end
		case (s_d.state)
			ST_ADDR: begin
				s_d.pins.addrLatchStrobe = 1'b1;
				s_d.pins.port0Out        = s_d.addr[7:0];
				s_d.pins.port0Oe         = 1'b1;
				// high byte for the whole cycle
				s_d.pins.port2Out        = s_d.addr[15:8];
			end
			ST_ALEOFF: begin
				// address still driven as the latch strobe falls
				s_d.pins.port0Out = s_d.addr[7:0];
				s_d.pins.port0Oe  = 1'b1;
				s_d.pins.port2Out = s_d.addr[15:8];
			end
			ST_SETUP: begin
				// data ahead of the write strobe
				s_d.pins.port0Out = s_d.wdata;
				s_d.pins.port0Oe  = 1'b1;
				s_d.pins.port2Out = s_d.addr[15:8];
			end
			ST_STROBE: begin
				s_d.pins.port2Out = s_d.addr[15:8];
				if (s_d.op == OP_WRITE) begin
					s_d.pins.port0Out         = s_d.wdata;
					s_d.pins.port0Oe          = 1'b1;
					s_d.pins.dataWriteStrobeN = 1'b0;
				end else if (s_d.op == OP_FETCH) begin
					// code reads use their own strobe
					s_d.pins.codeReadStrobeN = 1'b0;
				end else begin
					s_d.pins.dataReadStrobeN = 1'b0;
				end
			end
			ST_RELEASE: begin
				s_d.pins.port2Out = s_d.addr[15:8];
				// write data outlasts the strobe by one cycle
				if (s_d.op == OP_WRITE) begin
					s_d.pins.port0Out = s_d.wdata;
					s_d.pins.port0Oe  = 1'b1;
				end
			end
			default: begin
			end
		endcase

		// registered read of the special registers
		case (sfrAddr)
			SFR_PTR_LOW:    s_d.sfrRd = bankRd[7:0];
			SFR_PTR_HIGH:   s_d.sfrRd = bankRd[15:8];
			SFR_PTR_SELECT: s_d.sfrRd = {5'b0_0000, s_q.select};
			default:        s_d.sfrRd = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q.state    <= ST_IDLE;
			s_q.cnt      <= 4'h0;
			s_q.op       <= OP_FETCH;
			s_q.addr     <= 16'h0000;
			s_q.wdata    <= 8'h00;
			s_q.rdata    <= 8'h00;
			s_q.select   <= SEL_RESET;
			s_q.extExec  <= 1'b0;
			s_q.lastHigh <= 8'h00;
			s_q.ready    <= 1'b1;
			s_q.done     <= 1'b0;
			s_q.doneExt  <= 1'b0;
			s_q.sfrRd    <= 8'h00;
			s_q.loadOnes <= 1'b0;
			s_q.pins     <= PINS_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// port 2 latch is only read here, never written
	assign reqReady           = s_q.ready;
	assign doneValid          = s_q.done;
	assign doneData           = s_q.rdata;
	assign doneExternal       = s_q.doneExt;
	assign sfrRdata           = s_q.sfrRd;
	assign activePointer      = bankRd;
	assign port0LatchLoadOnes = s_q.loadOnes;
	assign port2Dedicated     = s_q.extExec;
	assign pins               = s_q.pins;

endmodule

/* logic/ebdp_pkg.sv */
package ebdp_pkg;

	// special-function addresses seen on the core's register port
	localparam logic [7:0]  SFR_PTR_LOW        = 8'h82;
	localparam logic [7:0]  SFR_PTR_HIGH       = 8'h83;
	localparam logic [7:0]  SFR_PTR_SELECT     = 8'h92;

	// highest program address that internal code memory covers
	localparam logic [15:0] INTERNAL_CODE_TOP  = 16'h1FFF;
	localparam logic [7:0]  PORT0_ALL_ONES     = 8'hFF;

	localparam int          PTR_COUNT          = 8;
	localparam int          PTR_WIDTH          = 16;
	localparam int          SEL_WIDTH          = 3;
	localparam logic [2:0]  SEL_RESET          = 3'h0;
	localparam logic [15:0] PTR_RESET          = 16'h0000;

	// bus phase lengths in clock cycles (50 ns each)
	localparam logic [3:0]  ADDR_CYCLES        = 4'h1;
	localparam logic [3:0]  CODE_STROBE_CYCLES = 4'h1;
	localparam logic [3:0]  DATA_STROBE_CYCLES = 4'h3;

	typedef enum logic [5:0] {
		ST_IDLE    = 6'b00_0001,
		ST_ADDR    = 6'b00_0010,
		ST_ALEOFF  = 6'b00_0100,
		ST_SETUP   = 6'b00_1000,
		ST_STROBE  = 6'b01_0000,
		ST_RELEASE = 6'b10_0000
	} ebdp_state_t;

	typedef enum logic [1:0] {
		OP_FETCH = 2'h0,
		OP_READ  = 2'h1,
		OP_WRITE = 2'h2
	} ebdp_op_t;

	// one request from the core: code fetch or external move
	typedef struct packed {
		ebdp_op_t    op;
		logic        viaPointer;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} ebdp_req_t;

	// pin-side outputs, all registered
	typedef struct packed {
		logic [7:0] port0Out;
		logic       port0Oe;
		logic [7:0] port2Out;
		logic       addrLatchStrobe;
		logic       codeReadStrobeN;
		logic       dataReadStrobeN;
		logic       dataWriteStrobeN;
	} ebdp_pins_t;

	localparam ebdp_pins_t PINS_RESET = '{
		port0Out: 8'h00, port0Oe: 1'b0, port2Out: 8'h00, addrLatchStrobe: 1'b0,
		codeReadStrobeN: 1'b1, dataReadStrobeN: 1'b1, dataWriteStrobeN: 1'b1
	};

endpackage

/* logic/ebdp_ptr_bank.sv */
`timescale 1ns/1ns
module ebdp_ptr_bank
	import ebdp_pkg::*;
#(
	parameter int DEPTH = PTR_COUNT,
	parameter int WIDTH = PTR_WIDTH,
	parameter int IDXW  = SEL_WIDTH
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// write port, byte-masked
	input  wire logic             wrEn,
	input  wire logic [IDXW-1:0]  wrIdx,
	input  wire logic [1:0]       wrMask,
	input  wire logic [WIDTH-1:0] wrData,
	// read port, registered
	input  wire logic [IDXW-1:0]  rdIdx,
	output logic      [WIDTH-1:0] rdData
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] entry;
		logic [WIDTH-1:0]            rd;
	} ebdp_bank_t;

	ebdp_bank_t bank_q;
	ebdp_bank_t bank_d;
	logic [DEPTH-1:0][WIDTH-1:0] nextEntry;

	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			always_comb begin
				nextEntry[i] = bank_q.entry[i];
				if (wrEn && wrIdx == IDXW'(i)) begin
					if (wrMask[0]) begin
						nextEntry[i][7:0] = wrData[7:0];
					end
					if (wrMask[1]) begin
						nextEntry[i][WIDTH-1:8] = wrData[WIDTH-1:8];
					end
				end
			end
		end
	endgenerate

	// read after write, so the core never sees a stale active pointer
	always_comb begin
		bank_d       = bank_q;
		bank_d.entry = nextEntry;
		bank_d.rd    = nextEntry[rdIdx];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_q <= '0;
		end else begin
			bank_q <= bank_d;
		end
	end

	assign rdData = bank_q.rd;

endmodule

/* verification/ebdp_bus_ctrl_properties.sv */
`timescale 1ns/1ns
module ebdp_bus_ctrl_props
	import ebdp_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// core side
	input wire logic        reqValid,
	input wire ebdp_req_t   req,
	input wire logic        reqReady,
	input wire logic        doneValid,
	input wire logic [7:0]  doneData,
	input wire logic        doneExternal,
	input wire logic [15:0] activePointer,
	// straps and bus
	input wire logic        extAccessInN,
	input wire logic [7:0]  port2Latch,
	input wire logic        port0LatchLoadOnes,
	input wire logic [7:0]  port0In,
	input wire ebdp_pins_t  pins
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic take, extF, intF, mv;
	assign take = reqValid && reqReady;
	assign extF = take && req.op == OP_FETCH && (!extAccessInN || req.addr > INTERNAL_CODE_TOP);
	assign intF = take && req.op == OP_FETCH && !extF;
	assign mv = take && req.op != OP_FETCH;

	wr_data_held_a: assert property (
		!pins.dataWriteStrobeN || $rose(pins.dataWriteStrobeN) |-> pins.port0Oe && $stable(pins.port0Out))
		else $error("write data moved around the write strobe");
	rd_capture_a: assert property (
		$rose(pins.dataReadStrobeN) || $rose(pins.codeReadStrobeN) |->
		##1 doneValid && doneData == $past(port0In, 2))
		else $error("read byte not captured under the strobe");
	strobe_split_a: assert property (
		!pins.codeReadStrobeN |-> pins.dataReadStrobeN && pins.dataWriteStrobeN)
		else $error("code strobe overlaps a data strobe");
	ext_fetch_a: assert property (
		extF |-> ##1 !reqReady ##4 doneValid && doneExternal)
		else $error("external fetch not run on the bus");
	int_fetch_a: assert property (
		intF |-> ##[1:2] doneValid && !doneExternal)
		else $error("internal fetch went wrong");
	fetch_addr_a: assert property (
		extF |-> ##1 pins.addrLatchStrobe && pins.port2Out == $past(req.addr[15:8])
		&& pins.port0Out == $past(req.addr[7:0]) ##1 !pins.addrLatchStrobe
		&& pins.port0Out == $past(req.addr[7:0], 2) ##1 !pins.codeReadStrobeN)
		else $error("fetch address wrong on the ports");
	ptr_move_a: assert property (
		mv && req.viaPointer |-> ##1 pins.port2Out == $past(activePointer[15:8])
		&& pins.port0Out == $past(activePointer[7:0]))
		else $error("pointer move address wrong");
	reg_move_a: assert property (
		mv && !req.viaPointer |-> ##1 pins.port2Out == $past(port2Latch)
		&& pins.port0Out == $past(req.addr[7:0]))
		else $error("register move address wrong");
	latch_ones_a: assert property (
		extF || mv |-> ##1 port0LatchLoadOnes)
		else $error("port 0 latch not loaded with ones");
endmodule

bind ebdp_bus_ctrl ebdp_bus_ctrl_props chk_u (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
	.req(req), .reqReady(reqReady), .doneValid(doneValid), .doneData(doneData),
	.doneExternal(doneExternal), .activePointer(activePointer), .extAccessInN(extAccessInN),
	.port2Latch(port2Latch), .port0LatchLoadOnes(port0LatchLoadOnes), .port0In(port0In),
	.pins(pins));

/* verification/ebdp_ext_mem.sv */
`timescale 1ns/1ns
module ebdp_ext_mem
	import ebdp_pkg::*;
(
	input wire logic       clk,
	input wire ebdp_pins_t pins,
	output logic     [7:0] port0In
);
	logic [15:0] addr = 16'h0000;
	logic [7:0]  last = 8'h00;
	logic [7:0]  mem [0:65535];
	bit          written [0:65535];
	logic        rdN;
	// unwritten places read back a pattern made from the address
	function automatic logic [7:0] peek(input logic [15:0] a, input logic code);
		if (!code && written[a])
			return mem[a];
		return a[7:0] ^ a[15:8] ^ (code ? 8'h55 : 8'h00);
	endfunction
	always @(negedge pins.addrLatchStrobe)
		addr = {pins.port2Out, pins.port0Out};
	always @(posedge pins.dataWriteStrobeN)
		if (pins.port0Oe === 1'b1) begin
			mem[addr] = pins.port0Out;
			written[addr] = 1'b1;
		end
	assign rdN = pins.dataReadStrobeN & pins.codeReadStrobeN;
	// byte presented; a released bus shows the inverse so stale data never matches
	always @*
		port0In = rdN ? ~last : peek(addr, pins.dataReadStrobeN);
	always @(posedge clk)
		if (!rdN)
			last <= port0In;
endmodule

/* verification/external_bus_datapointer_bank_test.sv */
`timescale 1ns/1ns
module external_bus_datapointer_bank_test;
	import ebdp_pkg::*;
	logic        clk = 0, rst_n = 0, reqValid = 0, sfrWe = 0, ptrInc = 0, extAccessInN = 1;
	logic [7:0]  sfrAddr = 8'h00, sfrWdata = 8'h00, port2Latch = 8'hC7;
	logic [7:0]  port0In, sfrRdata, doneData;
	logic        reqReady, doneValid, doneExternal, port0LatchLoadOnes, port2Dedicated;
	logic [15:0] activePointer;
	ebdp_req_t   req = '0;
	ebdp_pins_t  pins;
	int          err_total = 0, tests_run = 0;

	ebdp_bus_ctrl dut_u (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .req(req),
		.reqReady(reqReady), .doneValid(doneValid), .doneData(doneData),
		.doneExternal(doneExternal), .sfrWe(sfrWe), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
		.ptrInc(ptrInc), .sfrRdata(sfrRdata), .activePointer(activePointer),
		.extAccessInN(extAccessInN), .port2Latch(port2Latch),
		.port0LatchLoadOnes(port0LatchLoadOnes), .port2Dedicated(port2Dedicated),
		.port0In(port0In), .pins(pins));
	ebdp_ext_mem mem_u (.clk(clk), .pins(pins), .port0In(port0In));

	always #25 clk = ~clk;

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic run(input ebdp_op_t o, input logic v, input logic [15:0] a,
		input logic [7:0] w, input int lat, input logic x, input logic [7:0] e);
		int n;
		n = 0;
		@(posedge clk);
		#5;
		req = '{o, v, a, w};
		reqValid = 1;
		@(posedge clk);
		#5;
		reqValid = 0;
		while (doneValid !== 1'b1 && n < 12) begin
			@(posedge clk);
			#5;
			n++;
		end
		chk(16'(doneValid), 16'h0001);
		chk(16'(doneExternal), 16'(x));
		if (lat > 0)
			chk(16'(n), 16'(lat));
		if (x && o != OP_WRITE)
			chk(16'(doneData), 16'(e));
	endtask
	task automatic sw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#5;
		{sfrWe, sfrAddr, sfrWdata} = {1'b1, a, d};
		@(posedge clk);
		#5;
		sfrWe = 0;
	endtask
	task automatic sr(input logic [7:0] a, input logic [7:0] e);
		sfrAddr = a;
		repeat (2) @(posedge clk);
		#5;
		chk(16'(sfrRdata), 16'(e));
	endtask

	task automatic t_fetch;
		run(OP_FETCH, 0, 16'h1FFF, 8'h00, 0, 0, 8'h00);
		run(OP_FETCH, 0, 16'h2000, 8'h00, 4, 1, 8'h75);
		chk(16'(port2Dedicated), 16'h0001);
		chk(16'(pins.port2Out), 16'h0020);
		extAccessInN = 0;
		run(OP_FETCH, 0, 16'h0010, 8'h00, 4, 1, 8'h45);
		extAccessInN = 1;
		run(OP_FETCH, 0, 16'h0011, 8'h00, 0, 0, 8'h00);
		@(posedge clk);
		#5;
		chk(16'(pins.port2Out), 16'h00C7);
		chk(16'(port2Dedicated), 16'h0000);
		$display("t_fetch done");
	endtask
	task automatic t_ptr;
		sw(SFR_PTR_SELECT, 8'hFB);
		sr(SFR_PTR_SELECT, 8'h03);
		sw(SFR_PTR_HIGH, 8'h12);
		sw(SFR_PTR_LOW, 8'hFF);
		sw(SFR_PTR_SELECT, 8'h05);
		sw(SFR_PTR_HIGH, 8'hAB);
		sr(SFR_PTR_LOW, 8'h00);
		sw(SFR_PTR_SELECT, 8'h03);
		@(posedge clk);
		#5;
		ptrInc = 1;
		@(posedge clk);
		#5;
		ptrInc = 0;
		sr(SFR_PTR_HIGH, 8'h13);
		chk(activePointer, 16'h1300);
		sw(SFR_PTR_SELECT, 8'h05);
		sr(SFR_PTR_HIGH, 8'hAB);
		$display("t_ptr done");
	endtask
	task automatic t_move;
		run(OP_WRITE, 1, 16'h0000, 8'h5A, 7, 1, 8'h00);
		run(OP_READ, 1, 16'h0000, 8'h00, 6, 1, 8'h5A);
		run(OP_READ, 0, 16'h0034, 8'h00, 6, 1, 8'hF3);
		$display("t_move done");
	endtask

	task automatic end_of_test;
		$display("tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		#5;
		rst_n = 1;
		t_fetch();
		t_ptr();
		t_move();
		end_of_test();
	end
	// the tests need about 70 cycles; 2000 cycles leaves ample margin
	initial begin
		#100000;
		err_total++;
		end_of_test();
	end
endmodule
